// file: core/tvsync_pkg.sv
// Shared constants and types for the composite sync waveform generator.
// Assumes a 20 MHz system clock; pulse widths are given in ns and turned into cycles.
`default_nettype none

package tvsync_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned HS_NS = 6000;
    localparam int unsigned EQ_NS = 3000;
    localparam int unsigned VS_NS = 27000;
    localparam int unsigned SVS_NS = 190000;
    localparam int unsigned HB_NS = 11000;
    localparam int unsigned VB_NS = 1270000;
    // Least widths: round up to whole cycles
    localparam int unsigned HS_CYC = (HS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned EQ_CYC = (EQ_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned VS_CYC = (VS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SVS_CYC = (SVS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HB_CYC = (HB_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned VB_CYC = (VB_NS * CLK_MHZ + 999) / 1000;

    // ****************************************************************
    // Sequence
    // ****************************************************************
    localparam int unsigned SEQ_CNT_W = 3;
    localparam logic [SEQ_CNT_W-1:0] EQ_LAST = 3'h5;
    localparam logic [SEQ_CNT_W-1:0] VS_LAST = 3'h5;
    localparam logic [SEQ_CNT_W-1:0] SVS_LAST = 3'h2;
    localparam int unsigned POL_CSYNC = 0;
    localparam int unsigned POL_HBLK = 1;
    localparam int unsigned POL_VBLK = 2;
    localparam int unsigned POL_MBLK = 3;

    typedef enum logic [2:0] {
        SEQ_HORIZ,
        SEQ_EQ1,
        SEQ_VS,
        SEQ_EQ2,
        SEQ_SVS
    } tvsync_seq_t;
endpackage

`default_nettype wire

// file: core/tvsync_pulse.sv
// Counter-timed pulse: a start strobe opens the output for LEN system clocks.
// Assumes start is a one-cycle strobe; a start while busy retriggers.
`default_nettype none

module tvsync_pulse
    import tvsync_pkg::*;
#(
    parameter int unsigned LEN = 1
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic srst_i,
    // Control
    input wire logic start_i,
    // Pulse
    output logic busy_o
);
    localparam logic [CNT_W-1:0] LEN_V = CNT_W'(LEN - 1);

    logic [CNT_W-1:0] cnt_q;
    logic busy_q;
    wire logic last = (cnt_q == '0);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (srst_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (start_i) begin
            cnt_q <= LEN_V;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= last ? cnt_q : cnt_q - 1'b1;
            busy_q <= !last;
        end
    end

    assign busy_o = busy_q;
endmodule

`default_nettype wire

// file: core/tvsync_gen.sv
// Composite sync and blanking waveform generator, top level.
// Assumes CLKP_I, FIELD_I and VB_EARLY_I are synchronous levels from the sync counter chain.
//
// Summary of operation
// - In interlaced mode every horizontal, vertical and equalizing pulse starts at the falling edge of the clock pulse.
// - The half-rate divider and the sequence state change only at the rising edge of the clock pulse.
// - In interlaced mode a field trigger switches the output from horizontal sync to equalizing pulses.
// - In interlaced mode, after a field trigger come six equalizing, six vertical and six equalizing pulses, then horizontal sync again.
// - In interlaced mode, outside the vertical interval the divider lets horizontal sync through on every other clock pulse only.
// - Equalizing and horizontal sync pulses are never launched or active together.
// - The composite output is taken from the horizontal/equalizing source or from the vertical source.
// - Separate horizontal and vertical blanking are produced and also mixed into one blanking output.
// - In simplified mode horizontal blanking starts on the rising clock pulse edge and sync on the falling edge.
// - In simplified mode a field trigger puts the vertical pulse on the output for three line periods.
// - Each sync and blanking output can be inverted.
`default_nettype none

module tvsync_gen
    import tvsync_pkg::*;
#(
    parameter int unsigned HS_LEN = HS_CYC,
    parameter int unsigned EQ_LEN = EQ_CYC,
    parameter int unsigned VS_LEN = VS_CYC,
    parameter int unsigned SVS_LEN = SVS_CYC,
    parameter int unsigned HB_LEN = HB_CYC,
    parameter int unsigned VB_LEN = VB_CYC
) (
    // Clock and resets
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic SRST_I,
    // Configuration
    input wire logic MODE_I,
    input wire logic [3:0] POL_I,
    // Timing from the sync counter chain
    input wire logic CLKP_I,
    input wire logic FIELD_I,
    input wire logic VB_EARLY_I,
    // Waveform outputs
    output logic CSYNC_O,
    output logic HBLANK_O,
    output logic VBLANK_O,
    output logic MBLANK_O
);
    // ****************************************************************
    // Edge detection
    // ****************************************************************
    logic clkp_q;
    logic field_q;
    logic early_q;
    logic fld_pend_q;
    logic half_q;
    tvsync_seq_t state_q;
    tvsync_seq_t state_d;
    logic [SEQ_CNT_W-1:0] seq_cnt_q;
    logic [SEQ_CNT_W-1:0] seq_cnt_d;
    logic csync_q;
    logic hblank_q;
    logic vblank_q;
    logic mblank_q;

    wire logic lead = CLKP_I && !clkp_q;
    wire logic trail = !CLKP_I && clkp_q;
    wire logic field_rise = FIELD_I && !field_q;
    wire logic early_rise = VB_EARLY_I && !early_q;

    // ****************************************************************
    // Pulse launch decode
    // ****************************************************************
    wire logic in_horiz = (state_q == SEQ_HORIZ);
    wire logic eq_sel = (state_q == SEQ_EQ1) || (state_q == SEQ_EQ2);
    wire logic vs_sel = (state_q == SEQ_VS) || (state_q == SEQ_SVS);
    wire logic hs_gate = MODE_I || half_q;
    wire logic hs_start = trail && in_horiz && hs_gate;
    wire logic eq_start = trail && eq_sel;
    wire logic vs_start = trail && (state_q == SEQ_VS);
    // One vertical pulse per substitution; a retrigger on each line would stretch it past three lines
    wire logic svs_start = trail && (state_q == SEQ_SVS) && (seq_cnt_q == '0);
    wire logic hb_start = lead && (MODE_I || !half_q);
    wire logic accept = lead && fld_pend_q && in_horiz;
    wire logic vb_start = MODE_I ? early_rise : (accept && !MODE_I);
    wire logic hs_busy;
    wire logic eq_busy;
    wire logic vs_busy;
    wire logic svs_busy;
    wire logic hb_busy;
    wire logic vb_busy;
    wire logic hseq = eq_busy || (hs_busy && !eq_busy);
    wire logic vsrc = vs_busy || svs_busy;
    wire logic csync = vs_sel ? vsrc : hseq;
    wire logic mblank = hb_busy || vb_busy;
    wire logic [SEQ_CNT_W-1:0] last_cnt = (state_q == SEQ_SVS) ? SVS_LAST : (state_q == SEQ_VS) ? VS_LAST : EQ_LAST;
    wire logic seq_done = (seq_cnt_q == last_cnt);

    // ****************************************************************
    // Sequence control
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        seq_cnt_d = seq_cnt_q;
        if (accept) begin
            state_d = MODE_I ? SEQ_SVS : SEQ_EQ1;
            seq_cnt_d = '0;
        end else if (lead && !in_horiz) begin
            seq_cnt_d = seq_done ? '0 : seq_cnt_q + 1'b1;
            if (seq_done) begin
                unique case (state_q)
                    SEQ_EQ1: state_d = SEQ_VS;
                    SEQ_VS: state_d = SEQ_EQ2;
                    SEQ_EQ2: state_d = SEQ_HORIZ;
                    SEQ_SVS: state_d = SEQ_HORIZ;
                    default: state_d = SEQ_HORIZ;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            clkp_q <= 1'b0;
            field_q <= 1'b0;
            early_q <= 1'b0;
            fld_pend_q <= 1'b0;
            half_q <= 1'b0;
            state_q <= SEQ_HORIZ;
            seq_cnt_q <= '0;
        end else if (SRST_I) begin
            clkp_q <= 1'b0;
            field_q <= 1'b0;
            early_q <= 1'b0;
            fld_pend_q <= 1'b0;
            half_q <= 1'b0;
            state_q <= SEQ_HORIZ;
            seq_cnt_q <= '0;
        end else begin
            clkp_q <= CLKP_I;
            field_q <= FIELD_I;
            early_q <= VB_EARLY_I;
            fld_pend_q <= field_rise || (fld_pend_q && !accept);
            half_q <= lead ? !half_q : half_q;
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
        end
    end

    // ****************************************************************
    // Pulse timers
    // ****************************************************************
    // Horizontal sync
    tvsync_pulse #(.LEN(HS_LEN)) u_hs (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .srst_i(SRST_I),
        .start_i(hs_start),
        .busy_o(hs_busy)
    );
    // Equalizing pulse
    tvsync_pulse #(.LEN(EQ_LEN)) u_eq (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .srst_i(SRST_I),
        .start_i(eq_start),
        .busy_o(eq_busy)
    );
    // Vertical sync, interlaced sequence
    tvsync_pulse #(.LEN(VS_LEN)) u_vs (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .srst_i(SRST_I),
        .start_i(vs_start),
        .busy_o(vs_busy)
    );
    // Vertical sync, simplified substitution
    tvsync_pulse #(.LEN(SVS_LEN)) u_svs (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .srst_i(SRST_I),
        .start_i(svs_start),
        .busy_o(svs_busy)
    );
    // Horizontal blanking
    tvsync_pulse #(.LEN(HB_LEN)) u_hb (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .srst_i(SRST_I),
        .start_i(hb_start),
        .busy_o(hb_busy)
    );
    // Vertical blanking
    tvsync_pulse #(.LEN(VB_LEN)) u_vb (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .srst_i(SRST_I),
        .start_i(vb_start),
        .busy_o(vb_busy)
    );

    // ****************************************************************
    // Output stage
    // ****************************************************************
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            csync_q <= 1'b0;
            hblank_q <= 1'b0;
            vblank_q <= 1'b0;
            mblank_q <= 1'b0;
        end else begin
            csync_q <= csync ^ POL_I[POL_CSYNC];
            hblank_q <= hb_busy ^ POL_I[POL_HBLK];
            vblank_q <= vb_busy ^ POL_I[POL_VBLK];
            mblank_q <= mblank ^ POL_I[POL_MBLK];
        end
    end

    assign CSYNC_O = csync_q;
    assign HBLANK_O = hblank_q;
    assign VBLANK_O = vblank_q;
    assign MBLANK_O = mblank_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I || SRST_I);

    a_launch_on_trail: assert property ((hs_start || eq_start || vs_start) |-> !CLKP_I && $past(CLKP_I))
        else $error("sync pulse launched off the falling edge");
    a_state_on_lead: assert property (($changed(state_q) || $changed(half_q)) |-> $past(lead))
        else $error("sequence state changed off the rising edge");
    a_field_to_eq: assert property ((accept && !MODE_I) |=> state_q == SEQ_EQ1 && seq_cnt_q == 3'h0)
        else $error("field trigger did not start equalizing");
    a_seq_six_count: assert property ($rose(state_q == SEQ_VS) |-> $past(state_q) == SEQ_EQ1 && $past(seq_cnt_q) == 3'h5)
        else $error("vertical phase entered without six equalizing pulses");
    a_eq2_return: assert property ($rose(state_q == SEQ_HORIZ) |-> $past(seq_cnt_q) == 3'h5 || $past(seq_cnt_q) == 3'h2)
        else $error("sequence returned to horizontal too early");
    a_half_gate: assert property ((hs_start && !MODE_I) |-> half_q && $past(lead, 1) == 1'b0)
        else $error("horizontal sync passed on a suppressed pulse");
    a_eq_hs_excl: assert property (!(hs_start && eq_start) && !(eq_busy && hs_start))
        else $error("equalizing and horizontal sync together");
    a_sel_output: assert property (1'b1 |=> CSYNC_O == ($past(vs_sel ? vsrc : hseq) ^ $past(POL_I[POL_CSYNC])))
        else $error("composite output not from the selected source");
    a_mix_blank: assert property (1'b1 |=> MBLANK_O == (($past(hb_busy) || $past(vb_busy)) ^ $past(POL_I[POL_MBLK])))
        else $error("mixed blanking does not match the blanking pulses");
    a_simple_porch: assert property ((MODE_I && lead) |=> hb_busy ##0 (!hs_busy throughout (!trail)[*1]))
        else $error("blanking did not lead sync in simplified mode");
    a_simple_three: assert property ($rose(state_q == SEQ_SVS) |-> $past(MODE_I) && $past(accept))
        else $error("simplified vertical phase entered without a field trigger");
    a_early_vblank: assert property ((MODE_I && early_rise) |=> vb_busy)
        else $error("vertical blanking did not start on the early signal");

    // Timers answer their launch strobes
    a_hs_timer: assert property
        (hs_start |=> hs_busy)
        else $error("horizontal sync timer did not start");
    a_eq_timer: assert property
        (eq_start |=> eq_busy)
        else $error("equalizing timer did not start");
    a_vs_timer: assert property
        (vs_start |=> vs_busy)
        else $error("vertical sync timer did not start");
    a_hb_timer: assert property
        (hb_start |=> hb_busy)
        else $error("horizontal blanking timer did not start");
    a_vb_timer: assert property
        (vb_start |=> vb_busy)
        else $error("vertical blanking timer did not start");

    // Sequence checks
    a_svs_single: assert property
        (svs_start |-> seq_cnt_q == 3'h0)
        else $error("simplified vertical pulse launched more than once");
    a_no_hs_vert: assert property
        (!in_horiz |-> !hs_start)
        else $error("horizontal sync launched inside the vertical interval");
    a_vs_to_eq2: assert property
        ($fell(state_q == SEQ_VS) |-> state_q == SEQ_EQ2)
        else $error("vertical phase not followed by equalizing");
    a_accept_clear: assert property
        (accept |=> !fld_pend_q || $past(field_rise))
        else $error("accepted field trigger left pending");
    a_vb_std_mode: assert property
        (!MODE_I |-> vb_start == accept)
        else $error("vertical blanking started off the field accept");

    // Divider and simplified line timing
    a_hb_half: assert property
        ((!MODE_I && hb_start) |-> !half_q)
        else $error("horizontal blanking on a suppressed pulse");
    a_simple_every: assert property
        ((MODE_I && trail && in_horiz) |-> hs_start)
        else $error("simplified mode missed a horizontal sync");

    // Blanking outputs
    a_hblank_out: assert property
        (1'b1 |=> HBLANK_O == ($past(hb_busy) ^ $past(POL_I[POL_HBLK])))
        else $error("horizontal blanking output does not follow its timer");
    a_vblank_out: assert property
        (1'b1 |=> VBLANK_O == ($past(vb_busy) ^ $past(POL_I[POL_VBLK])))
        else $error("vertical blanking output does not follow its timer");
endmodule

`default_nettype wire

// file: testbench/tvsync_chain_model.sv
// Behavioural model of the upstream sync counter chain.
// Assumes one-cycle request strobes from the bench on the system clock.
`default_nettype none

module tvsync_chain_model #(
    parameter int unsigned PER = 64,
    parameter int unsigned HI = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Requests from the bench
    input wire logic field_req_i,
    input wire logic early_req_i,
    // Timing levels
    output logic clkp_o,
    output logic field_o,
    output logic early_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic [1:0] fld_q;
    logic [1:0] erl_q;

    // Free-running clock pulse train, one pulse per period
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 8'h00;
            fld_q <= 2'h0;
            erl_q <= 2'h0;
        end else begin
            cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
            fld_q <= field_req_i ? 2'h3 : fld_q - {1'b0, |fld_q};
            erl_q <= early_req_i ? 2'h3 : erl_q - {1'b0, |erl_q};
        end
    end

    assign clkp_o = cnt_q < 8'(HI);
    assign field_o = |fld_q;
    assign early_o = |erl_q;
endmodule

`default_nettype wire

// file: testbench/tvsync_gen_tb.sv
// Self-checking bench for the composite sync and blanking generator.
// Assumes the chain model supplies clock pulses; widths are shortened.
`default_nettype none

module tvsync_gen_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PER = 64;
    localparam int HI = 8;
    localparam int HS = 10, EQ = 5, VS = 30, SVS = 150, HB = 15, VB = 200;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic srst = 1'b0;
    logic mode = 1'b0;
    logic [3:0] pol = 4'h0;
    logic field_req = 1'b0;
    logic early_req = 1'b0;
    logic clkp, field, early, csync, hblank, vblank, mblank;
    logic [3:0] outs;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int run_w [4] = '{0, 0, 0, 0};
    int last_w [4] = '{0, 0, 0, 0};
    int rise_t [4] = '{0, 0, 0, 0};
    int nrise [4] = '{0, 0, 0, 0};

    always #25 clk = ~clk;
    always @(posedge clk) cyc++;
    assign outs = {mblank, vblank, hblank, csync} ^ pol;

    tvsync_chain_model #(.PER(PER), .HI(HI)) u_chain (.clk_i(clk), .nrst_i(nrst),
        .field_req_i(field_req), .early_req_i(early_req), .clkp_o(clkp), .field_o(field), .early_o(early));

    tvsync_gen #(.HS_LEN(HS), .EQ_LEN(EQ), .VS_LEN(VS), .SVS_LEN(SVS), .HB_LEN(HB), .VB_LEN(VB)) u_dut (
        .CLK_I(clk), .NRST_I(nrst), .SRST_I(srst), .MODE_I(mode), .POL_I(pol), .CLKP_I(clkp),
        .FIELD_I(field), .VB_EARLY_I(early), .CSYNC_O(csync), .HBLANK_O(hblank), .VBLANK_O(vblank),
        .MBLANK_O(mblank));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Pulse widths, start times and counts of every active-level output
    always @(negedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (outs[i] === 1'b1) begin
                if (run_w[i] == 0) begin
                    rise_t[i] = cyc;
                    nrise[i]++;
                end
                run_w[i]++;
            end else begin
                if (run_w[i] != 0) last_w[i] = run_w[i];
                run_w[i] = 0;
            end
        end
        if (nrst) check("mixed_blank", outs[3], outs[1] | outs[2]);
    end

    task automatic do_reset(input logic m, input logic [3:0] p);
        @(posedge clk);
        nrst <= 1'b0;
        mode <= m;
        pol <= p;
        repeat (6) @(posedge clk);
        check("reset_out", {28'h0, mblank, vblank, hblank, csync}, 32'h0);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic strobe(input bit fld);
        @(posedge clk);
        if (fld) field_req <= 1'b1;
        else early_req <= 1'b1;
        @(posedge clk);
        field_req <= 1'b0;
        early_req <= 1'b0;
    endtask

    // Waits for the next composite sync pulse, bounded
    task automatic next_pulse(output int w, output int t0);
        int n;
        n = 0;
        w = 0;
        while (outs[0] !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        t0 = cyc;
        while (outs[0] === 1'b1 && w < 400) begin
            @(negedge clk);
            w++;
        end
    endtask

    task automatic t_line();
        int w, t0, t1;
        do_reset(1'b0, 4'h0);
        next_pulse(w, t0);
        next_pulse(w, t1);
        check("hs_width", w, HS);
        check("hs_spacing", t1 - t0, 2 * PER);
        check("porch", t1 - rise_t[1], HI);
        check("hb_width", last_w[1], HB);
    endtask

    task automatic t_field();
        int w, t0, tp, k, n0;
        do_reset(1'b0, 4'h0);
        n0 = nrise[2];
        strobe(1'b0);
        repeat (2 * PER) @(posedge clk);
        check("early_ignored", nrise[2] - n0, 0);
        next_pulse(w, t0);
        strobe(1'b1);
        for (k = 0; k < 19; k++) begin
            tp = t0;
            next_pulse(w, t0);
            check("vert_seq", w, (k >= 6 && k < 12) ? VS : (k < 18 ? EQ : HS));
            if (k == 1) check("eq_spacing", t0 - tp, PER);
        end
        check("vb_width", last_w[2], VB);
    endtask

    task automatic t_simple();
        int w, t0, t1, k;
        do_reset(1'b1, 4'h0);
        next_pulse(w, t0);
        next_pulse(w, t1);
        check("shs_spacing", t1 - t0, PER);
        check("s_porch", t1 - rise_t[1], HI);
        strobe(1'b0);
        for (k = 0; k < 3; k++) next_pulse(w, t0);
        strobe(1'b1);
        next_pulse(w, t0);
        check("svs_width", w, SVS);
        next_pulse(w, t0);
        check("hs_back", w, HS);
        check("s_vb_width", last_w[2], VB);
    endtask

    task automatic t_pol();
        int w, t0;
        do_reset(1'b0, 4'hf);
        next_pulse(w, t0);
        check("inv_hs", w, HS);
        check("inv_idle", csync, 1'b1);
        while (outs[1] !== 1'b1) @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        check("srst_out", {28'h0, mblank, vblank, hblank, csync}, 32'hf);
        srst <= 1'b0;
        next_pulse(w, t0);
        check("srst_hs", w, HS);
    endtask

    initial begin
        t_line();
        t_field();
        t_simple();
        t_pol();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule

`default_nettype wire
